// ==== verilog/ssp_pkg.sv ====
// Purpose: Shared constants for the sensor serial port host controller
// Assumes: 100 MHz system clock
// Notes: Timing figures kept in ns, cycle counts derived from them
package ssp_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	// Link clock limit: 5 MHz gives 200 ns period
	localparam int unsigned SCLK_MIN_PERIOD_NS = 200;
	localparam int unsigned SCLK_HALF_CYC = (SCLK_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Select low to first falling edge
	localparam int unsigned DELAY_NS = 5;
	localparam int unsigned DELAY_CYC = (DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Last rising edge to select high
	localparam int unsigned QUIET_NS = 5;
	localparam int unsigned QUIET_CYC = (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Select high time between transfers
	localparam int unsigned CS_DIS_NS = 150;
	localparam int unsigned CS_DIS_CYC = (CS_DIS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Command byte layout
	localparam int unsigned CMD_RW_BIT = 7;
	localparam int unsigned CMD_BURST_BIT = 6;
	localparam int unsigned ADDR_W = 6;
	localparam logic [7:0] CMD_RESET = 8'h00;
	// Wire-count select register and bit in the device
	localparam logic [5:0] FORMAT_REG_ADDR = 6'h31;
	localparam int unsigned FORMAT_WIRE_BIT = 6;
	typedef enum logic [2:0] {
		SSP_IDLE = 3'b000,
		SSP_SETUP = 3'b001,
		SSP_SHIFT = 3'b010,
		SSP_NEXT = 3'b011,
		SSP_QUIET = 3'b100,
		SSP_GAP = 3'b101
	} ssp_state_t;
endpackage : ssp_pkg

// ==== verilog/ssp_sync.sv ====
// Purpose: Two-flop synchroniser for one level
// Assumes: Input from another domain
// Notes: First stage read only by second
`timescale 1ns/1ps
`default_nettype none
module ssp_sync (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic din,
	output logic dout
);
	logic meta;
	// Two stages, reset to high as the data line idles pulled
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta <= 1'b1;
			dout <= 1'b1;
		end else if (ce) begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule : ssp_sync
`default_nettype wire

// ==== verilog/ssp_clkdiv.sv ====
// Purpose: Tick generator for half periods of the serial clock
// Assumes: HALF >= 1
// Notes: Restarts on clear so every frame starts with a full half period
`timescale 1ns/1ps
`default_nettype none
module ssp_clkdiv #(
	parameter int unsigned HALF = 10
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic clr,
	output logic tick
);
	logic [15:0] cnt;
	// Count down one half period, pulse at zero
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 16'h0000;
			tick <= 1'b0;
		end else if (ce) begin
			if (clr || cnt == 16'h0000) begin
				cnt <= 16'(HALF - 1);
			end else begin
				cnt <= cnt - 16'h0001;
			end
			tick <= !clr && cnt == 16'h0000;
		end
	end
endmodule : ssp_clkdiv
`default_nettype wire

// ==== verilog/ssp_host.sv ====
// Purpose: Host-side controller driving the accelerometer serial port
// Assumes: Command port on clk_sys; device pins reached directly
// Notes: Serial clock made here by a divider, mode 3 framing
`timescale 1ns/1ps
`default_nettype none
module ssp_host #(
	parameter int unsigned SCLK_HALF = ssp_pkg::SCLK_HALF_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic mode_3wire,
	input wire logic cmd_valid,
	input wire logic cmd_read,
	input wire logic cmd_burst,
	input wire logic [5:0] cmd_addr,
	input wire logic [7:0] cmd_len,
	output logic cmd_ready,
	input wire logic [7:0] wr_data,
	output logic wr_take,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic done,
	output logic cs_n,
	output logic sclk,
	output logic sdi,
	input wire logic sdo,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe_n
);
	ssp_pkg::ssp_state_t state;
	logic tick;
	logic clr;
	logic [3:0] bitc;
	logic [7:0] left;
	logic [7:0] shreg;
	logic is_read;
	logic three;
	logic phase_cmd;
	logic [7:0] wait_cnt;
	logic sdo_s;
	logic sdio_s;
	logic rx_bit;
	// Edge strobes and hand-off qualifiers
	logic fall_tick;
	logic rise_tick;
	logic cmd_take;
	logic load_wr;

	// Both returning lines are pins, so both are synchronised
	ssp_sync u_sync_sdo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.din(sdo),
		.dout(sdo_s)
	);
	ssp_sync u_sync_sdio (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.din(sdio_in),
		.dout(sdio_s)
	);

	// Divider runs only while shifting
	// Half period sets the link rate; too slow a rate starves fast output rates
	assign clr = (state != ssp_pkg::SSP_SHIFT);
	ssp_clkdiv #(
		.HALF(SCLK_HALF)
	) u_div (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.clr(clr),
		.tick(tick)
	);

	// Data source follows the wire count latched at frame start
	assign rx_bit = three ? sdio_s : sdo_s;

	// Frame sequencer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= ssp_pkg::SSP_IDLE;
			wait_cnt <= 8'h00;
			cs_n <= 1'b1;
			cmd_ready <= 1'b0;
			done <= 1'b0;
			is_read <= 1'b0;
			three <= 1'b0;
			left <= 8'h00;
		end else if (ce) begin
			done <= 1'b0;
			unique case (state)
				ssp_pkg::SSP_IDLE: begin
					cs_n <= 1'b1;
					cmd_ready <= 1'b1;
					if (cmd_valid && cmd_ready) begin
						cmd_ready <= 1'b0;
						is_read <= cmd_read;
						three <= mode_3wire;
						// Single byte unless the burst flag is set
						left <= cmd_burst ? cmd_len : 8'h01;
						cs_n <= 1'b0;
						wait_cnt <= 8'(ssp_pkg::DELAY_CYC);
						state <= ssp_pkg::SSP_SETUP;
					end
				end
				ssp_pkg::SSP_SETUP: begin
					if (wait_cnt <= 8'h01) begin
						state <= ssp_pkg::SSP_SHIFT;
					end else begin
						wait_cnt <= wait_cnt - 8'h01;
					end
				end
				ssp_pkg::SSP_SHIFT: begin
					if (tick && sclk == 1'b0 && bitc == 4'h7) begin
						state <= ssp_pkg::SSP_NEXT;
					end
				end
				ssp_pkg::SSP_NEXT: begin
					// In burst mode each byte after the command steps the device pointer
					if (!phase_cmd && left <= 8'h01) begin
						wait_cnt <= 8'(ssp_pkg::QUIET_CYC);
						state <= ssp_pkg::SSP_QUIET;
					end else begin
						if (!phase_cmd) begin
							left <= left - 8'h01;
						end
						state <= ssp_pkg::SSP_SHIFT;
					end
				end
				ssp_pkg::SSP_QUIET: begin
					if (wait_cnt <= 8'h01) begin
						// Whole bytes only, so no partial byte is ever framed
						cs_n <= 1'b1;
						wait_cnt <= 8'(ssp_pkg::CS_DIS_CYC);
						state <= ssp_pkg::SSP_GAP;
					end else begin
						wait_cnt <= wait_cnt - 8'h01;
					end
				end
				ssp_pkg::SSP_GAP: begin
					if (wait_cnt <= 8'h01) begin
						done <= 1'b1;
						state <= ssp_pkg::SSP_IDLE;
					end else begin
						wait_cnt <= wait_cnt - 8'h01;
					end
				end
				default: begin
					cs_n <= 1'b1;
					state <= ssp_pkg::SSP_IDLE;
				end
			endcase
		end
	end

	// Serial clock: idle high, toggled by divider ticks while shifting
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sclk <= 1'b1;
		end else if (ce) begin
			if (state == ssp_pkg::SSP_SHIFT && tick) begin
				sclk <= ~sclk;
			end else if (state != ssp_pkg::SSP_SHIFT) begin
				sclk <= 1'b1;
			end
		end
	end

	// Divider ticks split by the serial clock edge that they make
	assign fall_tick = (state == ssp_pkg::SSP_SHIFT) && tick && sclk;
	assign rise_tick = (state == ssp_pkg::SSP_SHIFT) && tick && !sclk;
	assign cmd_take = (state == ssp_pkg::SSP_IDLE) && cmd_valid && cmd_ready;
	// Write byte loaded after the command and after every data byte but the last
	assign load_wr = !is_read && (phase_cmd || left > 8'h01);

	// Bit counter: counts rising edges, wraps after a whole byte
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bitc <= 4'h0;
		end else if (ce) begin
			if (cmd_take) begin
				bitc <= 4'h0;
			end else if (rise_tick) begin
				// Wrap here so the sequencer sees seven on the last edge
				if (bitc == 4'h7) begin
					bitc <= 4'h0;
				end else begin
					bitc <= bitc + 4'h1;
				end
			end
		end
	end

	// Command phase flag: set for the first byte, cleared once it is out
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase_cmd <= 1'b1;
		end else if (ce) begin
			if (cmd_take) begin
				phase_cmd <= 1'b1;
			end else if (state == ssp_pkg::SSP_NEXT) begin
				phase_cmd <= 1'b0;
			end
		end
	end

	// Shift register: loaded per byte, shifts in on every rising edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			shreg <= ssp_pkg::CMD_RESET;
		end else if (ce) begin
			if (cmd_take) begin
				// Command byte, MSB first
				shreg <= {cmd_read, cmd_burst, cmd_addr};
			end else if (rise_tick) begin
				// Bits returned during a write land here and are never used
				shreg <= {shreg[6:0], rx_bit};
			end else if (state == ssp_pkg::SSP_NEXT) begin
				if (load_wr) begin
					shreg <= wr_data;
				end else begin
					// Ones keep the input line quiet while a read shifts in
					shreg <= 8'hff;
				end
			end
		end
	end

	// Outgoing bit changes only on falling edges, so it is steady at each rise
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sdi <= 1'b1;
			sdio_out <= 1'b1;
		end else if (ce) begin
			if (fall_tick) begin
				sdi <= shreg[7];
				sdio_out <= shreg[7];
			end
		end
	end

	// Shared line: driven in 3-wire mode except while read data comes back
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sdio_oe_n <= 1'b1;
		end else if (ce) begin
			if (fall_tick) begin
				// Turnaround on the same falling edge the device starts on
				sdio_oe_n <= !three || (is_read && !phase_cmd);
			end else if (state == ssp_pkg::SSP_QUIET) begin
				sdio_oe_n <= 1'b1;
			end
		end
	end

	// Write hand-off: one pulse per data byte taken from wr_data
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_take <= 1'b0;
		end else if (ce) begin
			wr_take <= (state == ssp_pkg::SSP_NEXT) && load_wr;
		end
	end

	// Read byte: completed on the eighth rising edge of a data byte
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
		end else if (ce) begin
			rd_valid <= 1'b0;
			// Last bit is taken straight from the synchronised line
			if (rise_tick && bitc == 4'h7 && is_read && !phase_cmd) begin
				rd_data <= {shreg[6:0], rx_bit};
				rd_valid <= 1'b1;
			end
		end
	end
endmodule : ssp_host
`default_nettype wire

// ==== dv/ssp_host_sva.sv ====
// Purpose: Port checks for ssp_host
// Assumes: ce held high
// Notes: Bound to every ssp_host
`timescale 1ns/1ps
`default_nettype none
module ssp_host_chk (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic wr_take,
	input wire logic rd_valid,
	input wire logic done,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic sdio_oe_n
);
	// One domain only
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	idle_clk_a: assert property (cs_n |-> sclk)
		else $error("sclk low idle");
	data_hold_a: assert property ($rose(sclk) && !cs_n |-> $stable(sdi) ##1 $stable(sdi))
		else $error("sdi moved at rise");
	lead_in_a: assert property ($fell(cs_n) |-> sclk ##1 sclk)
		else $error("no lead in");
	quiet_end_a: assert property ($rose(cs_n) |-> sclk && $stable(sclk))
		else $error("no quiet time");
	low_time_a: assert property (!cs_n && $fell(sclk) |-> (!sclk)[*8])
		else $error("sclk low short");
	high_time_a: assert property (!cs_n && $rose(sclk) |-> sclk[*8])
		else $error("sclk high short");
	select_gap_a: assert property ($rose(cs_n) |-> cs_n[*8] ##1 cs_n[*7])
		else $error("gap short");
	frame_start_a: assert property (cmd_valid && cmd_ready |=> !cs_n)
		else $error("no select");
	busy_ready_a: assert property (!cs_n |-> !cmd_ready)
		else $error("ready in frame");
	line_free_a: assert property (cs_n ##1 cs_n |-> sdio_oe_n)
		else $error("sdio held");
	c_rd: cover property (rd_valid);
	c_wr: cover property (wr_take);
	c_done: cover property (done);
endmodule : ssp_host_chk
bind ssp_host ssp_host_chk chk_u (.clk_sys, .rst_n, .cmd_valid, .cmd_ready, .wr_take,
	.rd_valid, .done, .cs_n, .sclk, .sdi, .sdio_oe_n);
`default_nettype wire

// ==== dv/ssp_dev_model.sv ====
// Purpose: Behavioural accelerometer serial port
// Assumes: Mode 3 framing, 64 registers
// Notes: Released output toggles, never stale
`timescale 1ns/1ps
`default_nettype none
module ssp_dev_model (
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic sdio,
	output logic dout,
	output logic drv
);
	logic [7:0] mem [64];
	logic [7:0] cmd, sh;
	logic [5:0] ptr;
	int n;
	// Wire count from format register
	wire tw = mem[ssp_pkg::FORMAT_REG_ADDR][ssp_pkg::FORMAT_WIRE_BIT];
	initial begin
		foreach (mem[k]) mem[k] = 8'h00;
		dout = 1'b0;
		drv = 1'b0;
	end
	always @(negedge cs_n) n = 0;
	// Release at once on select high
	always @(posedge cs_n) begin
		drv = 1'b0;
		dout = ~dout;
	end
	// Capture on rise; whole bytes only
	always @(posedge sclk) if (!cs_n) begin
		sh = {sh[6:0], tw ? sdio : sdi};
		n++;
		if (n == 8) begin
			cmd = sh;
			ptr = sh[5:0];
		end else if (n % 8 == 0) begin
			if (!cmd[7]) mem[ptr] = sh;
			ptr = ptr + 6'(cmd[6]);
		end
	end
	// Drive on fall; junk during writes
	always @(negedge sclk) if (!cs_n) begin
		if (n >= 8 && cmd[7]) begin
			dout = mem[ptr][7 - n % 8];
			drv = 1'b1;
		end else dout = ~dout;
	end
endmodule : ssp_dev_model
`default_nettype wire

// ==== dv/ssp_host_tb.sv ====
// Purpose: Self-checking bench for ssp_host
// Assumes: ce high, pull-up on sdio
// Notes: Far side is ssp_dev_model
`timescale 1ns/1ps
`default_nettype none
module ssp_host_tb;
	logic clk_sys, rst_n, cmd_valid, cmd_read, cmd_burst, mode_3wire, cmd_ready, wr_take;
	logic rd_valid, done, cs_n, sclk, sdi, sdio_out, sdio_oe_n, dout, drv;
	logic [5:0] cmd_addr;
	logic [7:0] cmd_len, wr_data, rd_data;
	logic [7:0] wq[$], rq[$];
	int n_fail, checks, cyc, nt;
	// Pull-up when nobody drives
	wire sdio = !sdio_oe_n ? sdio_out : (drv ? dout : 1'b1);
	ssp_host dut_u (.clk_sys, .rst_n, .ce(1'b1), .mode_3wire, .cmd_valid, .cmd_read,
		.cmd_burst, .cmd_addr, .cmd_len, .cmd_ready, .wr_data, .wr_take, .rd_data, .rd_valid,
		.done, .cs_n, .sclk, .sdi, .sdo(dout), .sdio_in(sdio), .sdio_out, .sdio_oe_n);
	ssp_dev_model dev_u (.cs_n, .sclk, .sdi, .sdio, .dout, .drv);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// One frame; next byte handed over after each take
	task automatic xfer(input logic rd, input logic bst, input logic [5:0] a, input logic tw);
		nt = 0;
		rq.delete();
		while (cmd_ready !== 1'b1) @(negedge clk_sys);
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_read <= rd;
		cmd_burst <= bst;
		cmd_addr <= a;
		cmd_len <= 8'h03;
		mode_3wire <= tw;
		wr_data <= wq.size() ? wq[0] : 8'h00;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		for (int c = 0; c < 3000 && done !== 1'b1; c++) begin
			@(posedge clk_sys);
			if (nt < wq.size()) wr_data <= wq[nt];
			@(negedge clk_sys);
			if (wr_take === 1'b1) nt++;
			if (rd_valid === 1'b1) rq.push_back(rd_data);
		end
		// A frame that never ends counts as a mismatch
		chk(8'(done), 8'h01);
	endtask : xfer
	task automatic t_burst();
		wq = '{8'ha5, 8'h3c, 8'h0f};
		xfer(1'b0, 1'b1, 6'h3d, 1'b0);
		chk(8'(nt), 8'h03);
		for (int k = 0; k < 3; k++) chk(dev_u.mem[61 + k], wq[k]);
		chk(dev_u.mem[60], 8'h00);
		xfer(1'b1, 1'b1, 6'h3d, 1'b0);
		chk(8'(rq.size()), 8'h03);
		for (int k = 0; k < 3; k++) chk(rq[k], wq[k]);
	endtask : t_burst
	// Length ignored without burst flag
	task automatic t_single();
		wq = '{8'h77, 8'h66};
		xfer(1'b0, 1'b0, 6'h10, 1'b0);
		chk(dev_u.mem[16], 8'h77);
		chk(dev_u.mem[17], 8'h00);
	endtask : t_single
	task automatic t_3wire();
		wq = '{8'(1 << ssp_pkg::FORMAT_WIRE_BIT)};
		xfer(1'b0, 1'b0, ssp_pkg::FORMAT_REG_ADDR, 1'b0);
		xfer(1'b1, 1'b0, ssp_pkg::FORMAT_REG_ADDR, 1'b1);
		chk(rq[0], wq[0]);
		wq = '{8'h5a};
		xfer(1'b0, 1'b0, 6'h20, 1'b1);
		chk(dev_u.mem[32], 8'h5a);
	endtask : t_3wire
	task automatic end_of_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	// Hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		rst_n = 1'b0;
		{cmd_valid, cmd_read, cmd_burst, mode_3wire} = 4'h0;
		cmd_addr = 6'h00;
		cmd_len = 8'h00;
		wr_data = 8'h00;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_burst();
		t_single();
		t_3wire();
		end_of_test();
	end
endmodule : ssp_host_tb
`default_nettype wire
